//--- mbf_pkg.sv
package mbf_pkg;
    // function codes served by the handler
    localparam logic [7:0] FN_READ_HOLD = 8'h03;
    localparam logic [7:0] FN_READ_INPUT = 8'h04;
    localparam logic [7:0] FN_EXEC = 8'h05;
    localparam logic [7:0] FN_STORE = 8'h06;
    // exception framing
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_ILLEGAL_FN = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_VAL = 8'h03;
    // operation codes for the execute function
    localparam logic [15:0] OP_NOP = 16'h0000;
    localparam logic [15:0] OP_RESET = 16'h0001;
    localparam logic [15:0] OP_CLR_EVENTS = 16'h0005;
    localparam logic [15:0] OP_CLR_OSC = 16'h0006;
    localparam logic [15:0] OP_VIN_BASE = 16'h1000;
    localparam logic [15:0] OP_VIN_LAST = 16'h103F;
    localparam logic [15:0] EXEC_VALUE = 16'hFF00;
    // frame crc: reflected polynomial, all-ones start
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    // frame lengths and limits
    localparam logic [7:0] REQ_LEN = 8'h08;
    localparam logic [7:0] MIN_LEN = 8'h04;
    localparam logic [7:0] RX_CNT_MAX = 8'hFF;
    localparam int BUF_DEPTH = 8;
    localparam int MAX_REGS_DEF = 125;
    localparam int NUM_VIN_DEF = 64;

    // one byte through the crc, low bit first
    function automatic logic [15:0] crc16_byte(input logic [15:0] crc_in, input logic [7:0] data_in);
        logic [15:0] c;
        c = crc_in ^ {8'h00, data_in};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage

//--- mbf_handler.sv
`timescale 1ns/1ps

// Functional notes
// RULE_01: read replies words, high byte first
// RULE_02: read count limited to 125 registers
// RULE_03: codes 03h and 04h read identically
// RULE_04: start address alone picks data kind
// RULE_05: master sends read request in fixed order
// RULE_06: read reply: address, function, bytecount, data, crc
// RULE_07: execute carries 16-bit operation code, high first
// RULE_08: execute code value fixed FF00
// RULE_09: execute reply echoes request exactly
// RULE_10: operation 0000 does nothing but echo
// RULE_11: operation 0001 raises reset action
// RULE_12: operation 0005 clears event records
// RULE_13: operation 0006 clears waveform captures
// RULE_14: operations 1000-103F drive virtual inputs
// RULE_15: store single writes one 16-bit setting
// RULE_16: master sends store request in fixed order
// RULE_17: store reply echoes request exactly
// RULE_18: reflected crc-16, all-ones start
// RULE_19: bad data or function gets exception
// RULE_20: bad crc or address: silent drop
// RULE_21: register map lives outside this block
module mbf_handler
    import mbf_pkg::*;
#(
    parameter int MAX_REGS = MAX_REGS_DEF,
    parameter int NUM_VIN = NUM_VIN_DEF
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // own slave address
    input wire logic [7:0] slave_addr_in,
    // request bytes from the frame transport
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_valid_in,
    input wire logic rx_frame_end_in,
    // reply bytes to the frame transport
    output logic [7:0] tx_byte_out,
    output logic tx_valid_out,
    output logic tx_last_out,
    input wire logic tx_ready_in,
    // register store read port
    output logic rd_en_out,
    output logic [15:0] rd_addr_out,
    input wire logic [15:0] rd_data_in,
    // register store write port
    output logic wr_en_out,
    output logic [15:0] wr_addr_out,
    output logic [15:0] wr_data_out,
    // operation actions
    output logic op_reset_out,
    output logic op_clr_events_out,
    output logic op_clr_osc_out,
    output logic [NUM_VIN-1:0] vin_state_out
);

    // refuse sizes the counters cannot carry
    if (MAX_REGS < 1 || MAX_REGS > 127) begin : g_bad_regs
        $error("MAX_REGS must be 1 to 127");
    end
    if (NUM_VIN < 1 || NUM_VIN > 64) begin : g_bad_vin
        $error("NUM_VIN must be 1 to 64");
    end

    typedef enum logic [3:0] {
        ST_RX, ST_DECODE, ST_ECHO, ST_HDR, ST_RD_REQ, ST_RD_WAIT,
        ST_RD_CAP, ST_DHI, ST_DLO, ST_CRC_LO, ST_CRC_HI
    } mbf_state_t;

    mbf_state_t state_q, state_d; // sequencer
    logic [7:0] rx_cnt_q, rx_cnt_d; // bytes seen in frame, saturating
    logic [7:0] buf_q [BUF_DEPTH]; // first request bytes
    logic [7:0] buf_d [BUF_DEPTH];
    logic [15:0] crc_rx_q, crc_rx_d; // running crc of request
    logic [15:0] crc_tx_q, crc_tx_d; // running crc of reply
    logic exc_q, exc_d; // reply is an exception
    logic [7:0] exc_code_q, exc_code_d;
    logic [2:0] idx_q, idx_d; // byte index in echo or header
    logic [6:0] rd_left_q, rd_left_d; // registers still to send
    logic [15:0] rd_addr_q, rd_addr_d;
    logic rd_en_q, rd_en_d;
    logic [15:0] word_q, word_d; // word being sent
    logic wr_en_q, wr_en_d;
    logic op_reset_q, op_reset_d;
    logic op_clr_ev_q, op_clr_ev_d;
    logic op_clr_osc_q, op_clr_osc_d;
    logic [NUM_VIN-1:0] vin_q, vin_d;
    logic [7:0] tx_byte_q, tx_byte_d; // one-byte output stage
    logic tx_vld_q, tx_vld_d;
    logic tx_last_q, tx_last_d;

    // request fields, valid once the frame is held
    logic [7:0] fn;
    logic [15:0] f_addr;
    logic [15:0] f_val;
    logic frame_ok, len_ok, op_known, is_read, out_free;
    logic [7:0] echo_byte;
    logic [5:0] vin_idx;
    assign fn = buf_q[1];
    assign f_addr = {buf_q[2], buf_q[3]};
    assign f_val = {buf_q[4], buf_q[5]};
    assign len_ok = (rx_cnt_q == REQ_LEN);
    assign echo_byte = buf_q[idx_q];
    assign vin_idx = f_addr[5:0];
    // RULE_03 both read codes
    assign is_read = (fn == FN_READ_HOLD) || (fn == FN_READ_INPUT);
    // output stage can take a byte this cycle
    assign out_free = !tx_vld_q || tx_ready_in;

    // RULE_18 crc residue check
    // a good frame leaves zero once its own crc is folded in
    assign frame_ok = (rx_cnt_q >= MIN_LEN) && (crc_rx_q == CRC_RESIDUE) && (buf_q[0] == slave_addr_in);

    // RULE_14 virtual input range
    assign op_known = (f_addr == OP_NOP) || (f_addr == OP_RESET) || (f_addr == OP_CLR_EVENTS)
        || (f_addr == OP_CLR_OSC)
        || (f_addr >= OP_VIN_BASE && f_addr <= OP_VIN_LAST && f_addr[5:0] < 6'(NUM_VIN - 1) + 6'h01)
        || (f_addr >= OP_VIN_BASE && f_addr <= OP_VIN_LAST && NUM_VIN == 64);

    // next-state and datapath
    always_comb begin
        logic push;
        logic push_crc;
        logic push_last;
        logic [7:0] pbyte;
        push = 1'b0;
        push_crc = 1'b0;
        push_last = 1'b0;
        pbyte = 8'h00;
        state_d = state_q;
        rx_cnt_d = rx_cnt_q;
        buf_d = buf_q;
        crc_rx_d = crc_rx_q;
        crc_tx_d = crc_tx_q;
        exc_d = exc_q;
        exc_code_d = exc_code_q;
        idx_d = idx_q;
        rd_left_d = rd_left_q;
        rd_addr_d = rd_addr_q;
        rd_en_d = 1'b0;
        word_d = word_q;
        wr_en_d = 1'b0;
        op_reset_d = 1'b0;
        op_clr_ev_d = 1'b0;
        op_clr_osc_d = 1'b0;
        vin_d = vin_q;
        tx_byte_d = tx_byte_q;
        tx_vld_d = tx_vld_q && !tx_ready_in;
        tx_last_d = tx_last_q;
        unique case (state_q)
            // gather bytes; the end marker is looked at only without a byte
            ST_RX: begin
                if (rx_valid_in) begin
                    if (rx_cnt_q < REQ_LEN) begin
                        buf_d[rx_cnt_q[2:0]] = rx_byte_in;
                    end
                    if (rx_cnt_q != RX_CNT_MAX) begin
                        rx_cnt_d = rx_cnt_q + 8'h01;
                    end
                    crc_rx_d = crc16_byte(crc_rx_q, rx_byte_in);
                end else if (rx_frame_end_in) begin
                    // RULE_20 silent discard
                    if (frame_ok) begin
                        state_d = ST_DECODE;
                    end else begin
                        rx_cnt_d = 8'h00;
                        crc_rx_d = CRC_INIT;
                    end
                end
            end
            // one cycle to judge the request
            ST_DECODE: begin
                idx_d = 3'd0;
                exc_d = 1'b0;
                crc_tx_d = CRC_INIT;
                state_d = ST_HDR;
                if (is_read) begin
                    // RULE_02 count limit
                    if (!len_ok || f_val == 16'h0000 || f_val > 16'(MAX_REGS)) begin
                        exc_d = 1'b1;
                        exc_code_d = EXC_ILLEGAL_VAL;
                    end else begin
                        // RULE_04 address picks data
                        rd_addr_d = f_addr;
                        rd_left_d = f_val[6:0];
                    end
                end else if (fn == FN_EXEC) begin
                    // RULE_08 fixed code value
                    if (!len_ok || f_val != EXEC_VALUE || !op_known) begin
                        exc_d = 1'b1;
                        exc_code_d = EXC_ILLEGAL_VAL;
                    end else begin
                        // RULE_07 operation code dispatch
                        state_d = ST_ECHO;
                        // RULE_11 reset action
                        op_reset_d = (f_addr == OP_RESET);
                        // RULE_12 clear event records
                        op_clr_ev_d = (f_addr == OP_CLR_EVENTS);
                        // RULE_13 clear waveform captures
                        op_clr_osc_d = (f_addr == OP_CLR_OSC);
                        // RULE_14 toggle virtual input
                        if (f_addr >= OP_VIN_BASE) begin
                            vin_d[vin_idx] = !vin_q[vin_idx];
                        end
                        // RULE_10 no-op only echoes
                    end
                end else if (fn == FN_STORE) begin
                    if (!len_ok) begin
                        exc_d = 1'b1;
                        exc_code_d = EXC_ILLEGAL_VAL;
                    end else begin
                        // RULE_15 single setting write
                        wr_en_d = 1'b1;
                        state_d = ST_ECHO;
                    end
                end else begin
                    // RULE_19 unsupported function
                    exc_d = 1'b1;
                    exc_code_d = EXC_ILLEGAL_FN;
                end
            end
            // RULE_09 echo request bytes
            // RULE_17 store echo unchanged
            ST_ECHO: begin
                if (out_free) begin
                    push = 1'b1;
                    pbyte = echo_byte;
                    idx_d = idx_q + 3'd1;
                    if (idx_q == 3'd7) begin
                        push_last = 1'b1;
                        state_d = ST_RX;
                        rx_cnt_d = 8'h00;
                        crc_rx_d = CRC_INIT;
                    end
                end
            end
            // RULE_06 reply header
            // RULE_19 exception header
            ST_HDR: begin
                if (out_free) begin
                    push = 1'b1;
                    push_crc = 1'b1;
                    idx_d = idx_q + 3'd1;
                    if (idx_q == 3'd0) begin
                        pbyte = buf_q[0];
                    end else if (idx_q == 3'd1) begin
                        pbyte = exc_q ? (fn | EXC_FLAG) : fn;
                    end else begin
                        pbyte = exc_q ? exc_code_q : {rd_left_q, 1'b0};
                        state_d = exc_q ? ST_CRC_LO : ST_RD_REQ;
                    end
                end
            end
            // fetch one register from the store
            ST_RD_REQ: begin
                rd_en_d = 1'b1;
                state_d = ST_RD_WAIT;
            end
            ST_RD_WAIT: begin
                state_d = ST_RD_CAP;
            end
            // store answers one cycle after the strobe
            ST_RD_CAP: begin
                word_d = rd_data_in;
                state_d = ST_DHI;
            end
            // RULE_01 high byte first
            ST_DHI: begin
                if (out_free) begin
                    push = 1'b1;
                    push_crc = 1'b1;
                    pbyte = word_q[15:8];
                    state_d = ST_DLO;
                end
            end
            ST_DLO: begin
                if (out_free) begin
                    push = 1'b1;
                    push_crc = 1'b1;
                    pbyte = word_q[7:0];
                    rd_left_d = rd_left_q - 7'd1;
                    rd_addr_d = rd_addr_q + 16'h0001;
                    state_d = (rd_left_q == 7'd1) ? ST_CRC_LO : ST_RD_REQ;
                end
            end
            // RULE_18 crc low then high
            ST_CRC_LO: begin
                if (out_free) begin
                    push = 1'b1;
                    pbyte = crc_tx_q[7:0];
                    state_d = ST_CRC_HI;
                end
            end
            ST_CRC_HI: begin
                if (out_free) begin
                    push = 1'b1;
                    push_last = 1'b1;
                    pbyte = crc_tx_q[15:8];
                    state_d = ST_RX;
                    rx_cnt_d = 8'h00;
                    crc_rx_d = CRC_INIT;
                end
            end
            default: begin
                state_d = ST_RX;
            end
        endcase
        // load the output stage
        if (push) begin
            tx_byte_d = pbyte;
            tx_vld_d = 1'b1;
            tx_last_d = push_last;
            if (push_crc) begin
                crc_tx_d = crc16_byte(crc_tx_q, pbyte);
            end
        end
    end

    // register everything
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            state_q <= ST_RX;
            rx_cnt_q <= 8'h00;
            buf_q <= '{default: 8'h00};
            crc_rx_q <= CRC_INIT;
            crc_tx_q <= CRC_INIT;
            exc_q <= 1'b0;
            exc_code_q <= 8'h00;
            idx_q <= 3'd0;
            rd_left_q <= 7'd0;
            rd_addr_q <= 16'h0000;
            rd_en_q <= 1'b0;
            word_q <= 16'h0000;
            wr_en_q <= 1'b0;
            op_reset_q <= 1'b0;
            op_clr_ev_q <= 1'b0;
            op_clr_osc_q <= 1'b0;
            vin_q <= '0;
            tx_byte_q <= 8'h00;
            tx_vld_q <= 1'b0;
            tx_last_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rx_cnt_q <= rx_cnt_d;
            buf_q <= buf_d;
            crc_rx_q <= crc_rx_d;
            crc_tx_q <= crc_tx_d;
            exc_q <= exc_d;
            exc_code_q <= exc_code_d;
            idx_q <= idx_d;
            rd_left_q <= rd_left_d;
            rd_addr_q <= rd_addr_d;
            rd_en_q <= rd_en_d;
            word_q <= word_d;
            wr_en_q <= wr_en_d;
            op_reset_q <= op_reset_d;
            op_clr_ev_q <= op_clr_ev_d;
            op_clr_osc_q <= op_clr_osc_d;
            vin_q <= vin_d;
            tx_byte_q <= tx_byte_d;
            tx_vld_q <= tx_vld_d;
            tx_last_q <= tx_last_d;
        end
    end

    // RULE_21 store map stays outside
    assign rd_en_out = rd_en_q;
    assign rd_addr_out = rd_addr_q;
    assign wr_en_out = wr_en_q;
    assign wr_addr_out = f_addr;
    assign wr_data_out = f_val;
    assign op_reset_out = op_reset_q;
    assign op_clr_events_out = op_clr_ev_q;
    assign op_clr_osc_out = op_clr_osc_q;
    assign vin_state_out = vin_q;
    assign tx_byte_out = tx_byte_q;
    assign tx_valid_out = tx_vld_q;
    assign tx_last_out = tx_last_q;

    // checks on the sequencer
    a_read_count_limit: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_02
        rd_en_out |-> (rd_left_q != 7'd0) && (32'(rd_left_q) <= MAX_REGS))
        else $error("read count out of range");
    a_reset_action_cause: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_11
        op_reset_out |-> (fn == FN_EXEC) && (f_addr == OP_RESET) && $past(state_q == ST_DECODE))
        else $error("reset action without its operation");
    a_clear_osc_cause: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_13
        op_clr_osc_out |-> (fn == FN_EXEC) && (f_addr == OP_CLR_OSC))
        else $error("capture clear without its operation");
    a_vin_toggle_once: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_14
        (state_q == ST_DECODE && fn == FN_EXEC && len_ok && f_val == EXEC_VALUE && op_known
            && f_addr >= OP_VIN_BASE) |=> (vin_state_out != $past(vin_state_out)))
        else $error("virtual input did not change");
    a_echo_byte_match: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_09
        (state_q == ST_ECHO && out_free) |=> tx_valid_out && (tx_byte_out == $past(echo_byte)))
        else $error("echo byte differs from request");
    a_read_bytecount: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_06
        (state_q == ST_HDR && idx_q == 3'd2 && !exc_q && out_free)
            |=> (tx_byte_out == {$past(rd_left_q), 1'b0}) ##1 (state_q == ST_RD_WAIT))
        else $error("bytecount not twice the count");
    a_exc_fn_flag: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_19
        (state_q == ST_HDR && idx_q == 3'd1 && exc_q && out_free) |=> tx_byte_out[7])
        else $error("exception function lacks top bit");
    a_bad_frame_drop: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_20
        (state_q == ST_RX && !rx_valid_in && rx_frame_end_in && !frame_ok)
            |=> (state_q == ST_RX) && (rx_cnt_q == 8'h00) [*2])
        else $error("bad frame not dropped");
    a_word_high_first: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_01
        (state_q == ST_DHI && out_free) |=> (tx_byte_out == $past(word_q[15:8])))
        else $error("register high byte not first");
    a_crc_tail_low: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE_18
        (state_q == ST_CRC_LO && out_free) |=> (tx_byte_out == $past(crc_tx_q[7:0])))
        else $error("crc low byte wrong");

endmodule // mbf_handler

//--- mbf_store_model.sv
`timescale 1ns/1ps
// register store on the handler's read port
module mbf_store_model (
    // clock
    input wire logic ref_clk_in,
    // read port
    input wire logic rd_en_in,
    input wire logic [15:0] rd_addr_in,
    output logic [15:0] rd_data_out
);
    logic hit_q = 1'b0; // answer cycle flag
    logic [15:0] word_q = 16'h0000; // word picked from the address every cycle
    logic [15:0] junk_q = 16'h0F0F; // churn so stale data never looks valid
    // data kind chosen by address only
    always_ff @(posedge ref_clk_in) begin
        hit_q <= rd_en_in;
        junk_q <= ~junk_q ^ 16'h1234;
        case (rd_addr_in)
            16'h4050: word_q <= 16'h0028;
            16'h4051: word_q <= 16'h012C;
            16'h4052: word_q <= 16'h0000;
            default: word_q <= ~rd_addr_in;
        endcase
    end
    // valid only the cycle after the request
    assign rd_data_out = hit_q ? word_q : junk_q;
endmodule // mbf_store_model

//--- mbf_handler_test.sv
`timescale 1ns/1ps
module mbf_handler_test;
    import mbf_pkg::*;
    typedef logic [7:0] mbf_bytes_t[$];
    // stimulus
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] rx_byte_in = 8'h00;
    logic rx_valid_in = 1'b0;
    logic rx_frame_end_in = 1'b0;
    logic tx_ready_in = 1'b0;
    // observed
    logic [7:0] tx_byte_out;
    logic tx_valid_out, tx_last_out, rd_en_out, wr_en_out;
    logic [15:0] rd_addr_out, rd_data_in, wr_addr_out, wr_data_out;
    logic op_reset_out, op_clr_events_out, op_clr_osc_out;
    logic [63:0] vin_state_out;
    // tallies
    int bad_count = 0;
    int check_count = 0;
    int n_rst = 0, n_evt = 0, n_osc = 0, n_wr = 0;
    logic [15:0] wa_q, wd_q;
    initial forever #4 ref_clk_in = ~ref_clk_in;
    mbf_handler #(.MAX_REGS(125), .NUM_VIN(64)) dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .slave_addr_in(8'h11), .rx_byte_in(rx_byte_in), .rx_valid_in(rx_valid_in),
        .rx_frame_end_in(rx_frame_end_in), .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out),
        .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in), .rd_en_out(rd_en_out),
        .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in), .wr_en_out(wr_en_out),
        .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .op_reset_out(op_reset_out),
        .op_clr_events_out(op_clr_events_out), .op_clr_osc_out(op_clr_osc_out),
        .vin_state_out(vin_state_out));
    mbf_store_model store (.ref_clk_in(ref_clk_in), .rd_en_in(rd_en_out), .rd_addr_in(rd_addr_out),
        .rd_data_out(rd_data_in));
    // count pulses per edge, so a stretched pulse shows up
    always @(posedge ref_clk_in) begin
        if (op_reset_out === 1'b1) n_rst++;
        if (op_clr_events_out === 1'b1) n_evt++;
        if (op_clr_osc_out === 1'b1) n_osc++;
        if (wr_en_out === 1'b1) begin
            n_wr++;
            wa_q = wr_addr_out;
            wd_q = wr_data_out;
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // own bit-serial frame crc appended low then high
    function automatic void add_crc(ref mbf_bytes_t q);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int j = 0; j < 8; j++) begin
                c = c[0] ? ({1'b0, c[15:1]} ^ 16'hA001) : {1'b0, c[15:1]};
            end
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endfunction
    // one byte a cycle, then the end pulse with valid low
    task automatic send(input mbf_bytes_t q);
        foreach (q[i]) begin
            @(negedge ref_clk_in);
            rx_valid_in = 1'b1;
            rx_byte_in = q[i];
        end
        @(negedge ref_clk_in);
        rx_valid_in = 1'b0;
        rx_frame_end_in = 1'b1;
        @(negedge ref_clk_in);
        rx_frame_end_in = 1'b0;
    endtask
    // byte is counted when valid and ready meet before the next edge
    task automatic expect_reply(input mbf_bytes_t e, input bit stall);
        int got;
        got = 0;
        for (int k = 0; k < 3000 && got < e.size(); k++) begin
            @(negedge ref_clk_in);
            tx_ready_in = !stall || (k % 3) != 0;
            if (tx_valid_out === 1'b1 && tx_ready_in) begin
                check("reply byte", {8'h00, tx_byte_out}, {8'h00, e[got]});
                check("last flag", {15'h0000, tx_last_out}, 16'(got == e.size() - 1));
                got++;
            end
        end
        if (got < e.size()) check("reply timeout", 16'(got), 16'(e.size()));
    endtask
    task automatic expect_silence();
        for (int k = 0; k < 40; k++) begin
            @(negedge ref_clk_in);
            check("silent", {15'h0000, tx_valid_out}, 16'h0000);
        end
    endtask
    task automatic test_read();
        mbf_bytes_t e;
        send('{8'h11, 8'h04, 8'h40, 8'h50, 8'h00, 8'h03, 8'hA7, 8'h4A});
        e = '{8'h11, 8'h04, 8'h06, 8'h00, 8'h28, 8'h01, 8'h2C, 8'h00, 8'h00, 8'h0D, 8'h60};
        expect_reply(e, 1'b1);
        e = '{8'h11, 8'h03, 8'h40, 8'h50, 8'h00, 8'h03};
        add_crc(e);
        send(e);
        e = '{8'h11, 8'h03, 8'h06, 8'h00, 8'h28, 8'h01, 8'h2C, 8'h00, 8'h00};
        add_crc(e);
        expect_reply(e, 1'b0);
        // largest legal count
        e = '{8'h11, 8'h03, 8'h20, 8'h00, 8'h00, 8'h7D};
        add_crc(e);
        send(e);
        e = '{8'h11, 8'h03, 8'hFA};
        for (int i = 0; i < 125; i++) begin
            e.push_back(~(8'h20 + 8'((i + 0) >> 8)));
            e.push_back(~8'(i));
        end
        add_crc(e);
        expect_reply(e, 1'b1);
        $display("test read done");
    endtask
    task automatic test_exec();
        mbf_bytes_t f;
        logic [15:0] ops[6] = '{16'h0000, 16'h0001, 16'h0005, 16'h0006, 16'h1000, 16'h103F};
        foreach (ops[i]) begin
            f = '{8'h11, 8'h05, ops[i][15:8], ops[i][7:0], 8'hFF, 8'h00};
            add_crc(f);
            send(f);
            expect_reply(f, 1'b0);
            @(negedge ref_clk_in);
            check("reset count", 16'(n_rst), 16'(i >= 1));
            check("event count", 16'(n_evt), 16'(i >= 2));
            check("osc count", 16'(n_osc), 16'(i >= 3));
            check("vin low", vin_state_out[15:0], 16'(i >= 4));
            check("vin high", vin_state_out[63:48], {i >= 5, 15'h0000});
        end
        $display("test exec done");
    endtask
    task automatic test_store();
        send('{8'h11, 8'h06, 8'h40, 8'h51, 8'h00, 8'hC8, 8'hCE, 8'hDD});
        expect_reply('{8'h11, 8'h06, 8'h40, 8'h51, 8'h00, 8'hC8, 8'hCE, 8'hDD}, 1'b1);
        check("write count", 16'(n_wr), 16'h0001);
        check("write addr", wa_q, 16'h4051);
        check("write data", wd_q, 16'h00C8);
        $display("test store done");
    endtask
    task automatic test_errors();
        mbf_bytes_t e;
        logic [7:0] bad[3][3] = '{'{8'h03, 8'h00, 8'h7E}, '{8'h04, 8'h00, 8'h00}, '{8'h05, 8'hFF, 8'h01}};
        foreach (bad[i]) begin
            e = '{8'h11, bad[i][0], 8'h10, 8'h00, bad[i][1], bad[i][2]};
            add_crc(e);
            send(e);
            e = '{8'h11, bad[i][0] | 8'h80, 8'h03};
            add_crc(e);
            expect_reply(e, 1'b0);
        end
        send('{8'h11, 8'h39, 8'hCD, 8'hF2});
        expect_reply('{8'h11, 8'hB9, 8'h01, 8'h93, 8'h95}, 1'b0);
        send('{8'h11, 8'h06, 8'h40, 8'h51, 8'h00, 8'hC8, 8'hCE, 8'hDE});
        expect_silence();
        e = '{8'h12, 8'h06, 8'h40, 8'h51, 8'h00, 8'hC8};
        add_crc(e);
        send(e);
        expect_silence();
        check("write count", 16'(n_wr), 16'h0001);
        $display("test errors done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (60000) @(posedge ref_clk_in);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (20) @(negedge ref_clk_in);
        check("valid in reset", {15'h0000, tx_valid_out}, 16'h0000);
        check("vin in reset", vin_state_out[15:0], 16'h0000);
        nrst_in = 1'b1;
        test_read();
        test_exec();
        test_store();
        test_errors();
        give_verdict();
    end
endmodule // mbf_handler_test
